// ---- rtl/e3tt_pkg.sv ----
/*
 * constants shared by the outbound trail-trace and error-mask logic:
 * register indices, reset values and overhead octet kinds.
 * assumes a 32-bit APB slave port with one register per aligned word.
 */
package e3tt_pkg;
	localparam int          TT_BYTES       = 16;
	localparam int          APB_ADDR_W     = 12;
	localparam logic [9:0]  IDX_TRAIL_0    = 10'h038;
	localparam logic [9:0]  IDX_TRAIL_12   = 10'h044;
	localparam logic [9:0]  IDX_TRAIL_13   = 10'h045;
	localparam logic [9:0]  IDX_TRAIL_14   = 10'h046;
	localparam logic [9:0]  IDX_TRAIL_15   = 10'h047;
	localparam logic [9:0]  IDX_FA1_MASK   = 10'h048;
	localparam logic [9:0]  IDX_FA2_MASK   = 10'h049;
	localparam logic [9:0]  IDX_EM_MASK    = 10'h04A;
	localparam logic [9:0]  IDX_STATUS     = 10'h04C;
	localparam logic [7:0]  REG_RST        = 8'h00;
	localparam logic [3:0]  FRAME_IDX_RST  = 4'hF;
	localparam logic [23:0] RD_PAD         = 24'h000000;

	// kind of octet presented on the outbound stream
	typedef enum logic [2:0] {
		KIND_PAYLOAD = 3'h0,
		KIND_FA1     = 3'h1,
		KIND_FA2     = 3'h2,
		KIND_EM      = 3'h3,
		KIND_TR      = 3'h4
	} e3tt_kind_t;
endpackage

// ---- rtl/e3tt_apb_regs.sv ----
/*
 * APB register file: sixteen trail bytes, three error masks, frame status.
 * assumes APB signalling from a master on clk; answers with one wait-free
 * access phase, unmapped or misaligned words give pslverr and zero data.
 */
module e3tt_apb_regs
	import e3tt_pkg::*;
#(
	parameter int ADDR_W = APB_ADDR_W
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [ADDR_W-1:0]             paddr,
	input  wire logic [31:0]                   pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	output logic      [TT_BYTES-1:0][7:0]      trailBytes,
	output logic      [7:0]                    fa1Mask,
	output logic      [7:0]                    fa2Mask,
	output logic      [7:0]                    emMask,
	input  wire logic [3:0]                    frameIdx
);
	logic       setup;
	logic       wrEn;
	logic       mapped;
	logic       inTrail;
	logic [9:0] regIdx;
	logic [3:0] trailSel;
	logic [7:0] rdByte;

	assign setup    = psel & ~penable;
	assign regIdx   = 10'(paddr[ADDR_W-1:2]);
	assign trailSel = 4'(regIdx - IDX_TRAIL_0);
	assign inTrail  = (regIdx >= IDX_TRAIL_0) && (regIdx <= IDX_TRAIL_15);
	// pready is high only in the access phase, so a write lands exactly once
	assign wrEn     = psel & penable & pready & pwrite & mapped & pstrb[0];

	always_comb begin
		mapped = (paddr[1:0] == 2'b00);
		rdByte = REG_RST;
		if (inTrail) begin
			rdByte = trailBytes[trailSel];
		end else if (regIdx == IDX_FA1_MASK) begin
			rdByte = fa1Mask;
		end else if (regIdx == IDX_FA2_MASK) begin
			rdByte = fa2Mask;
		end else if (regIdx == IDX_EM_MASK) begin
			rdByte = emMask;
		end else if (regIdx == IDX_STATUS) begin
			rdByte = {4'h0, frameIdx};
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite & mapped) ? {RD_PAD, rdByte} : 32'h00000000;
		end
	end

	for (genvar g = 0; g < TT_BYTES; g++) begin : gTrail
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				trailBytes[g] <= REG_RST;
			end else if (wrEn && inTrail && trailSel == 4'(g)) begin
				trailBytes[g] <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fa1Mask <= REG_RST;
			fa2Mask <= REG_RST;
			emMask  <= REG_RST;
		end else if (wrEn) begin
			if (regIdx == IDX_FA1_MASK) begin
				fa1Mask <= pwdata[7:0];
			end
			if (regIdx == IDX_FA2_MASK) begin
				fa2Mask <= pwdata[7:0];
			end
			if (regIdx == IDX_EM_MASK) begin
				emMask <= pwdata[7:0];
			end
		end
	end

	a_apb_ready_once: assert property (@(posedge clk) disable iff (sys_rst)
		(psel && !penable) |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");

	a_mask_reset_zero: assert property (@(posedge clk)
		$fell(sys_rst) |-> (fa1Mask == 8'h00 && fa2Mask == 8'h00 && emMask == 8'h00))
		else $error("error masks not zero after reset");

	a_reg_write_lands: assert property (@(posedge clk) disable iff (sys_rst)
		(wrEn && regIdx == IDX_EM_MASK) |=> emMask == $past(pwdata[7:0]))
		else $error("mask write not stored");
endmodule // e3tt_apb_regs

// ---- rtl/e3tt_trail_seq.sv ----
/*
 * modulo-16 frame counter with trail-byte fetch and one-frame send delay.
 * assumes frameStart is a one-cycle pulse on the first octet of each frame.
 */
module e3tt_trail_seq
	import e3tt_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     sys_rst,
	input  wire logic                     frameStart,
	input  wire logic [TT_BYTES-1:0][7:0] trailBytes,
	output logic      [3:0]               frameIdx,
	output logic      [7:0]               fetchByte,
	output logic      [7:0]               sendByte
);
	logic [3:0] frameIdx_nxt;

	assign frameIdx_nxt = frameIdx + 4'h1;

	// reset value makes the first frame seen index 0
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frameIdx <= FRAME_IDX_RST;
		end else if (frameStart) begin
			frameIdx <= frameIdx_nxt;
		end
	end

	// byte n is read at the start of frame n and sent through frame n+1
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fetchByte <= REG_RST;
			sendByte  <= REG_RST;
		end else if (frameStart) begin
			fetchByte <= trailBytes[frameIdx_nxt];
			sendByte  <= fetchByte;
		end
	end

	a_frame_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		(frameStart && frameIdx == 4'hF) |=> frameIdx == 4'h0)
		else $error("frame counter did not wrap to zero");

	a_fetch_matches_idx: assert property (@(posedge clk) disable iff (sys_rst)
		frameStart |=> fetchByte == $past(trailBytes[frameIdx_nxt]))
		else $error("fetched byte not selected by frame index");

	a_send_delay: assert property (@(posedge clk) disable iff (sys_rst)
		frameStart |=> sendByte == $past(fetchByte))
		else $error("send byte not one frame behind fetch");
endmodule // e3tt_trail_seq

// ---- rtl/e3tt_overhead_tx.sv ----
/*
 * outbound E3 overhead insertion: trail-trace octet fill and XOR error
 * masks on the two alignment octets and the error-monitor octet.
 * assumes the upstream framer on clk tags each octet with its kind and
 * marks the first octet of every frame; the octet pipe is one cycle deep.
 */
// Overview of operation
// - sixteen trail bytes sent, one per frame
// - frame thirteen fetches byte twelve, sent next
// - frame fourteen fetches byte thirteen, sent next
// - frame fifteen fetches byte fourteen, sent next
// - frame sixteen fetches byte fifteen, sent next
// - fetched byte goes out the following frame
// - first alignment octet XORed with its mask
// - second alignment octet XORed with its mask
// - error-monitor octet XORed with its mask
// - masks reset zero; keep zero normally
// - trail and mask registers eight bits, read/write, reset zero; status read-only, resets 0F
// - byte n fetched in frame n+1
// - trail bytes sit at consecutive addresses
module e3tt_overhead_tx
	import e3tt_pkg::*;
#(
	parameter int ADDR_W = APB_ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [7:0]        inOctet,
	input  wire logic [2:0]        inKind,
	input  wire logic              inFrameStart,
	input  wire logic              inValid,
	output logic      [7:0]        outOctet,
	output logic      [2:0]        outKind,
	output logic                   outFrameStart,
	output logic                   outValid
);
	logic [TT_BYTES-1:0][7:0] trailBytes;
	logic [7:0]               fa1Mask;
	logic [7:0]               fa2Mask;
	logic [7:0]               emMask;
	logic [3:0]               frameIdx;
	logic [7:0]               fetchByte;
	logic [7:0]               sendByte;
	logic                     frameStart;
	logic [7:0]               outOctet_nxt;

	// an unqualified start flag must not step the trail sequence
	assign frameStart = inValid & inFrameStart;

	e3tt_apb_regs #(
		.ADDR_W(ADDR_W)
	) uRegs (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.pstrb     (pstrb),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.trailBytes(trailBytes),
		.fa1Mask   (fa1Mask),
		.fa2Mask   (fa2Mask),
		.emMask    (emMask),
		.frameIdx  (frameIdx)
	);

	e3tt_trail_seq uSeq (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.frameStart(frameStart),
		.trailBytes(trailBytes),
		.frameIdx  (frameIdx),
		.fetchByte (fetchByte),
		.sendByte  (sendByte)
	);

	// a trail octet on the start beat already belongs to the new frame,
	// whose byte is the one still sitting in the fetch stage
	always_comb begin
		case (inKind)
			KIND_FA1: outOctet_nxt = inOctet ^ fa1Mask;
			KIND_FA2: outOctet_nxt = inOctet ^ fa2Mask;
			KIND_EM:  outOctet_nxt = inOctet ^ emMask;
			KIND_TR:  outOctet_nxt = inFrameStart ? fetchByte : sendByte;
			default:  outOctet_nxt = inOctet;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			outOctet <= REG_RST;
		end else if (inValid) begin
			outOctet <= outOctet_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			outKind       <= KIND_PAYLOAD;
			outFrameStart <= 1'b0;
			outValid      <= 1'b0;
		end else begin
			outKind       <= inKind;
			outFrameStart <= frameStart;
			outValid      <= inValid;
		end
	end

	a_fa1_xor_mask: assert property (@(posedge clk) disable iff (sys_rst)
		(inValid && inKind == KIND_FA1) |=> outOctet == ($past(inOctet) ^ $past(fa1Mask)))
		else $error("first alignment octet not masked");

	a_fa2_xor_mask: assert property (@(posedge clk) disable iff (sys_rst)
		(inValid && inKind == KIND_FA2) |=> outOctet == ($past(inOctet) ^ $past(fa2Mask)))
		else $error("second alignment octet not masked");

	a_em_xor_mask: assert property (@(posedge clk) disable iff (sys_rst)
		(inValid && inKind == KIND_EM) |=> outOctet == ($past(inOctet) ^ $past(emMask)))
		else $error("error-monitor octet not masked");

	a_trail_octet_fill: assert property (@(posedge clk) disable iff (sys_rst)
		(inValid && !inFrameStart && inKind == KIND_TR) |=> outOctet == $past(sendByte))
		else $error("trail octet not the delayed byte");

	// byte twelve is latched on the start beat of the thirteenth frame
	a_byte12_fetch: assert property (@(posedge clk) disable iff (sys_rst)
		(frameStart && frameIdx == 4'hB) |=> fetchByte == $past(trailBytes[12]))
		else $error("byte twelve not fetched in the thirteenth frame");

	a_payload_passes: assert property (@(posedge clk) disable iff (sys_rst)
		(inValid && inKind == KIND_PAYLOAD) |=> outOctet == $past(inOctet) && outValid)
		else $error("payload octet altered");
endmodule // e3tt_overhead_tx

// ---- tb/e3tt_line_sink.sv ----
/*
 * line-side sink model: keeps the last octet seen of each overhead kind.
 * assumes the block's outbound stream on clk, one octet per valid beat.
 */
module e3tt_line_sink
	import e3tt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] outOctet,
	input  wire logic [2:0] outKind,
	input  wire logic       outFrameStart,
	input  wire logic       outValid,
	output logic      [7:0] seen [5],
	output int              nStarts
);
	timeunit 1ns;
	timeprecision 100ps;

	// a receiver only listens, so it never drives the stream back
	always_ff @(posedge clk) begin
		if (outValid && outKind < 3'h5) begin
			seen[outKind] <= outOctet;
		end
	end

	// one count per frame start seen on the line
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			nStarts <= 0;
		end else if (outValid && outFrameStart) begin
			nStarts <= nStarts + 1;
		end
	end
endmodule // e3tt_line_sink

// ---- tb/e3tt_overhead_tx_tb.sv ----
/*
 * self-checking bench for the outbound trail-trace and error-mask block.
 * assumes the design package and a line-side sink model on the stream.
 */
module e3tt_overhead_tx_tb
	import e3tt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  inOctet = 8'h00;
	logic [2:0]  inKind = 3'h0;
	logic        inFrameStart = 1'b0;
	logic        inValid = 1'b0;
	logic [7:0]  outOctet;
	logic [2:0]  outKind;
	logic        outFrameStart;
	logic        outValid;
	logic [7:0]  seen [5];
	int          nStarts;
	logic [31:0] rd;
	logic        err;
	int          error_cnt = 0;
	int          n_tests = 0;

	e3tt_overhead_tx dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .inOctet(inOctet), .inKind(inKind),
		.inFrameStart(inFrameStart), .inValid(inValid), .outOctet(outOctet),
		.outKind(outKind), .outFrameStart(outFrameStart), .outValid(outValid));

	e3tt_line_sink sink (.clk(clk), .sys_rst(sys_rst), .outOctet(outOctet),
		.outKind(outKind), .outFrameStart(outFrameStart), .outValid(outValid),
		.seen(seen), .nStarts(nStarts));

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// request held until the edge where pready is sampled high
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
		int i;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk("pready", 8'h01, {7'h00, pready});
			summarize();
		end
	endtask

	task automatic beat(input logic [2:0] k, input logic [7:0] o, input logic s);
		@(posedge clk);
		inValid      <= 1'b1;
		inKind       <= k;
		inOctet      <= o;
		inFrameStart <= s;
	endtask

	// one short frame: start on the first alignment octet, trail octet fourth
	task automatic frame();
		int s0;
		s0 = nStarts;
		beat(KIND_FA1, 8'hF6, 1'b1);
		beat(KIND_FA2, 8'h28, 1'b0);
		beat(KIND_EM, 8'h5A, 1'b0);
		beat(KIND_TR, 8'h00, 1'b0);
		beat(KIND_PAYLOAD, 8'hC3, 1'b0);
		@(posedge clk);
		inValid      <= 1'b0;
		inFrameStart <= 1'b0;
		repeat (2) @(posedge clk);
		chk("frame starts", 8'(s0 + 1), 8'(nStarts));
	endtask

	task automatic t_reset();
		for (int n = 0; n < 19; n++) begin
			apb(1'b0, IDX_TRAIL_0 + 10'(n), 8'h00);
			chk("reset value", 8'h00, rd[7:0]);
		end
		$display("test reset done");
	endtask

	task automatic t_regs();
		for (int n = 0; n < TT_BYTES; n++) begin
			apb(1'b1, IDX_TRAIL_0 + 10'(n), 8'h30 + 8'(n));
		end
		for (int n = 0; n < TT_BYTES; n++) begin
			apb(1'b0, IDX_TRAIL_0 + 10'(n), 8'h00);
			chk("trail readback", 8'h30 + 8'(n), rd[7:0]);
			chk("read pad", 8'h00, rd[31:24]);
		end
		apb(1'b0, 10'h04D, 8'h00);
		chk("unmapped error", 8'h01, {7'h00, err});
		$display("test registers done");
	endtask

	// frame 0 sends zero; frame f sends byte f-1, wrapping after sixteen
	task automatic t_trail();
		logic [7:0] exp;
		for (int f = 0; f < 18; f++) begin
			frame();
			exp = (f == 0) ? 8'h00 : 8'h30 + 8'((f - 1) % 16);
			chk("trail octet", exp, seen[4]);
			chk("unmasked alignment", 8'hF6, seen[1]);
		end
		$display("test trail cycle done");
	endtask

	task automatic t_mask();
		apb(1'b1, IDX_FA1_MASK, 8'h81);
		apb(1'b1, IDX_FA2_MASK, 8'h3C);
		apb(1'b1, IDX_EM_MASK, 8'hFF);
		frame();
		chk("first alignment", 8'hF6 ^ 8'h81, seen[1]);
		chk("second alignment", 8'h28 ^ 8'h3C, seen[2]);
		chk("error monitor", 8'h5A ^ 8'hFF, seen[3]);
		apb(1'b0, IDX_EM_MASK, 8'h00);
		chk("mask readback", 8'hFF, rd[7:0]);
		$display("test masks done");
	endtask

	// nineteen frames so far leave index 2; a start-beat trail octet
	// must carry byte 2, the one still in the fetch stage
	task automatic t_corner();
		apb(1'b0, IDX_STATUS, 8'h00);
		chk("frame index", 8'h02, rd[7:0]);
		beat(KIND_TR, 8'h00, 1'b1);
		beat(KIND_PAYLOAD, 8'hC3, 1'b0);
		@(posedge clk);
		inValid      <= 1'b0;
		inFrameStart <= 1'b0;
		repeat (2) @(posedge clk);
		chk("trail on start beat", 8'h30 + 8'h02, seen[4]);
		pstrb <= 4'h0;
		apb(1'b1, IDX_FA1_MASK, 8'h00);
		pstrb <= 4'hF;
		chk("strobe error", 8'h00, {7'h00, err});
		apb(1'b0, IDX_FA1_MASK, 8'h00);
		chk("strobe-less write kept", 8'h81, rd[7:0]);
		// reset in mid-run: registers clear and the trail cycle restarts
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		apb(1'b0, IDX_FA1_MASK, 8'h00);
		chk("mask after reset", 8'h00, rd[7:0]);
		apb(1'b0, IDX_TRAIL_12, 8'h00);
		chk("trail after reset", 8'h00, rd[7:0]);
		apb(1'b0, IDX_STATUS, 8'h00);
		chk("index after reset", 8'h0F, rd[7:0]);
		frame();
		chk("first trail after reset", 8'h00, seen[4]);
		chk("unmasked after reset", 8'hF6, seen[1]);
		$display("test corner cases done");
	endtask

	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset();
		t_regs();
		t_trail();
		t_mask();
		t_corner();
		summarize();
	end
endmodule // e3tt_overhead_tx_tb
